/* File: design/clkgen_pkg.sv */
// constants, types and register field map of the clock generator mode control
// Function
// (RL1) bus divider 00 divides output by one
// (RL2) range bit selects high frequency oscillator
// (RL3) gain bit selects high gain oscillator
// (RL4) crystal select and external clock keep-alive bits
// (RL5) oscillator ready flag set after crystal start
// (RL6) source select picks loop, internal, external
// (RL7) reference divider field divides by powers two
// (RL8) reference select: zero external, one internal
// (RL9) status shows reference source in use
// (RL10) status shows clock feeding the output
// (RL11) software keeps FLL reference in range
// (RL12) software keeps PLL reference in range
// (RL13) loop select bit picks PLL or FLL
// (RL14) multiplier field ignored while FLL selected
// (RL15) status shows loop actually selected
// (RL16) lock flag set once loop locked
// (RL17) low power bypass disables both loops
// (RL18) plain bypass keeps FLL running, may lock
// (RL19) bus clock is output clock halved
// (RL20) software engages PLL via bypass first
// (RL21) software enters low power internal bypass
// (RL22) reset starts FLL internal, bus divide two
// (RL23) status updates only after switch completes
package clkgen_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ      = 20;
  localparam int unsigned OSC_INIT_NS  = 2000;
  localparam int unsigned LOCK_NS      = 4000;
  localparam int unsigned SWITCH_NS    = 150;
  localparam int unsigned OSC_INIT_CYC = (OSC_INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LOCK_CYC     = (LOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SWITCH_CYC   = (SWITCH_NS * CLK_MHZ + 999) / 1000;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [2:0] ADDR_CTRL_ONE   = 3'h0;
  localparam logic [2:0] ADDR_CTRL_TWO   = 3'h1;
  localparam logic [2:0] ADDR_CTRL_THREE = 3'h2;
  localparam logic [2:0] ADDR_STATUS     = 3'h3;
  localparam logic [7:0] CTRL_ONE_RST    = 8'h04;
  localparam logic [7:0] CTRL_TWO_RST    = 8'h40;
  localparam logic [7:0] CTRL_THREE_RST  = 8'h01;

  // ****************************************************************
  // fields
  // ****************************************************************
  localparam int SRC_SEL_HI   = 7;
  localparam int SRC_SEL_LO   = 6;
  localparam int REF_DIV_HI   = 5;
  localparam int REF_DIV_LO   = 3;
  localparam int INT_REF_BIT  = 2;
  localparam int BUS_DIV_HI   = 7;
  localparam int BUS_DIV_LO   = 6;
  localparam int FREQ_HI_BIT  = 5;
  localparam int GAIN_BIT     = 4;
  localparam int LOW_PWR_BIT  = 3;
  localparam int CRYSTAL_BIT  = 2;
  localparam int EXT_ON_BIT   = 1;
  localparam int LOOP_SEL_BIT = 6;
  localparam int MULT_HI      = 3;
  localparam int MULT_LO      = 0;

  // source select codes and active source codes
  localparam logic [1:0] SRC_LOOP = 2'h0;
  localparam logic [1:0] SRC_INT  = 2'h1;
  localparam logic [1:0] SRC_EXT  = 2'h2;
  localparam logic [1:0] ACT_FLL  = 2'h0;
  localparam logic [1:0] ACT_INT  = 2'h1;
  localparam logic [1:0] ACT_EXT  = 2'h2;
  localparam logic [1:0] ACT_PLL  = 2'h3;

  typedef enum logic [2:0] {
    fll_internal_mode,
    fll_external_mode,
    fll_bypass_internal_mode,
    fll_bypass_external_mode,
    pll_external_mode,
    pll_bypass_external_mode,
    low_power_internal_bypass,
    low_power_external_bypass
  } clock_mode_e;

endpackage : clkgen_pkg

/* File: design/clock_generator_mode_control.sv */
// mode control, status and output dividers of the clock generator
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
module clock_generator_mode_control
  import clkgen_pkg::*;
#(
  parameter int unsigned OSC_CYC    = OSC_INIT_CYC,
  parameter int unsigned LOCK_CYCS  = LOCK_CYC,
  parameter int unsigned SWITCH_CYCS = SWITCH_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // register port
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output      logic [7:0]  rdata,
  // oscillator controls
  output      logic        osc_range_high,
  output      logic        high_gain_osc,
  output      logic        ext_ref_select,
  output      logic        ext_ref_clock_enable,
  // loop controls
  output      logic        fll_enable,
  output      logic        pll_enable,
  output      logic [2:0]  reference_divider,
  output      logic [3:0]  loop_multiplier,
  output      logic        loop_locked,
  // output clock state
  output      logic [1:0]  clock_source_active,
  output      clock_mode_e clock_mode,
  output      logic        gen_clk_en,
  output      logic        bus_clk_en
);

  localparam int OSC_W  = $clog2(OSC_CYC + 1);
  localparam int LOCK_W = $clog2(LOCK_CYCS + 1);
  localparam int SW_W   = $clog2(SWITCH_CYCS + 1);

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [7:0] ctrl_one_q, ctrl_one_d;
  logic [7:0] ctrl_two_q, ctrl_two_d;
  logic [7:0] ctrl_three_q, ctrl_three_d;

  always_comb begin
    ctrl_one_d   = ctrl_one_q;
    ctrl_two_d   = ctrl_two_q;
    ctrl_three_d = ctrl_three_q;
    if (wr_en) begin
      case (addr)
        ADDR_CTRL_ONE:   ctrl_one_d   = wdata;
        ADDR_CTRL_TWO:   ctrl_two_d   = wdata;
        ADDR_CTRL_THREE: ctrl_three_d = wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_one_q   <= CTRL_ONE_RST;  // RL22
      ctrl_two_q   <= CTRL_TWO_RST;  // RL22
      ctrl_three_q <= CTRL_THREE_RST;
    end else begin
      ctrl_one_q   <= ctrl_one_d;
      ctrl_two_q   <= ctrl_two_d;
      ctrl_three_q <= ctrl_three_d;
    end
  end

  logic [1:0] src_sel;
  logic       int_ref_sel;
  logic       loop_sel;
  logic       low_pwr;
  logic       crystal;
  logic       ext_on;

  assign src_sel     = ctrl_one_q[SRC_SEL_HI:SRC_SEL_LO];
  assign int_ref_sel = ctrl_one_q[INT_REF_BIT];
  assign loop_sel    = ctrl_three_q[LOOP_SEL_BIT];
  assign low_pwr     = ctrl_two_q[LOW_PWR_BIT];
  assign crystal     = ctrl_two_q[CRYSTAL_BIT];
  assign ext_on      = ctrl_two_q[EXT_ON_BIT];

  assign osc_range_high       = ctrl_two_q[FREQ_HI_BIT];  // RL2
  assign high_gain_osc        = ctrl_two_q[GAIN_BIT];     // RL3
  assign ext_ref_select       = crystal;                  // RL4
  assign ext_ref_clock_enable = ext_on;                   // RL4
  assign reference_divider    = ctrl_one_q[REF_DIV_HI:REF_DIV_LO];  // RL7

  // ****************************************************************
  // source switching and status
  // ****************************************************************
  logic [1:0]       act_src_q, act_src_d;
  logic             act_loop_q, act_loop_d;
  logic             act_int_q, act_int_d;
  logic [3:0]       want_q, want_d;
  logic [SW_W-1:0]  sw_cnt_q, sw_cnt_d;
  logic [1:0]       tgt_src;
  logic [3:0]       want;
  logic             switch_done;

  // target source; loop output follows the loop actually selected
  always_comb begin
    case (src_sel)
      SRC_LOOP: tgt_src = act_loop_q ? ACT_PLL : ACT_FLL;  // RL6
      SRC_INT:  tgt_src = ACT_INT;                          // RL6
      SRC_EXT:  tgt_src = ACT_EXT;                          // RL6
      default:  tgt_src = act_src_q;
    endcase
  end

  assign want        = {tgt_src, loop_sel, int_ref_sel};
  assign switch_done = (sw_cnt_q == SW_W'(SWITCH_CYCS - 1));

  always_comb begin
    act_src_d  = act_src_q;
    act_loop_d = act_loop_q;
    act_int_d  = act_int_q;
    want_d     = want;
    sw_cnt_d   = '0;
    if (want != {act_src_q, act_loop_q, act_int_q}) begin
      if (want != want_q) begin
        sw_cnt_d = '0;
      end else if (switch_done) begin
        act_src_d  = tgt_src;      // RL10 RL23
        act_loop_d = loop_sel;     // RL13 RL15
        act_int_d  = int_ref_sel;  // RL8 RL9
      end else begin
        sw_cnt_d = sw_cnt_q + SW_W'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      act_src_q  <= ACT_FLL;  // RL22
      act_loop_q <= 1'b0;
      act_int_q  <= 1'b1;
      want_q     <= {ACT_FLL, 1'b0, 1'b1};
      sw_cnt_q   <= '0;
    end else begin
      act_src_q  <= act_src_d;
      act_loop_q <= act_loop_d;
      act_int_q  <= act_int_d;
      want_q     <= want_d;
      sw_cnt_q   <= sw_cnt_d;
    end
  end

  assign clock_source_active = act_src_q;

  // operating mode from the bits in force
  always_comb begin
    case (src_sel)
      SRC_INT:
        clock_mode = low_pwr ? low_power_internal_bypass
                             : fll_bypass_internal_mode;
      SRC_EXT:
        if (low_pwr)
          clock_mode = low_power_external_bypass;
        else
          clock_mode = loop_sel ? pll_bypass_external_mode
                                : fll_bypass_external_mode;
      default:
        if (loop_sel)
          clock_mode = pll_external_mode;
        else
          clock_mode = int_ref_sel ? fll_internal_mode : fll_external_mode;
    endcase
  end

  // ****************************************************************
  // crystal start-up
  // ****************************************************************
  logic             osc_rdy_q, osc_rdy_d;
  logic [OSC_W-1:0] osc_cnt_q, osc_cnt_d;
  logic             osc_needed;

  assign osc_needed = crystal && (ext_on || !int_ref_sel || src_sel == SRC_EXT);

  always_comb begin
    osc_rdy_d = osc_rdy_q;
    osc_cnt_d = osc_cnt_q;
    if (!osc_needed) begin
      osc_rdy_d = 1'b0;
      osc_cnt_d = '0;
    end else if (osc_cnt_q == OSC_W'(OSC_CYC - 1)) begin
      osc_rdy_d = 1'b1;  // RL5
    end else begin
      osc_cnt_d = osc_cnt_q + OSC_W'(1);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      osc_rdy_q <= 1'b0;
      osc_cnt_q <= '0;
    end else begin
      osc_rdy_q <= osc_rdy_d;
      osc_cnt_q <= osc_cnt_d;
    end
  end

  // ****************************************************************
  // loop enables and lock
  // ****************************************************************
  logic              fll_en_q, fll_en_d;
  logic              pll_en_q, pll_en_d;
  logic [3:0]        mult_q, mult_d;
  logic              locked_q, locked_d;
  logic [LOCK_W-1:0] lock_cnt_q, lock_cnt_d;
  logic [8:0]        cfg_q, cfg_d;
  logic              lp_bypass;

  assign lp_bypass = low_pwr && (src_sel != SRC_LOOP);
  assign mult_d    = act_loop_q ? ctrl_three_q[MULT_HI:MULT_LO] : 4'h0;  // RL14
  assign cfg_d     = {reference_divider, mult_d, act_loop_q, act_int_q};

  // lock drops in the same cycle as the loop enables
  always_comb begin
    fll_en_d   = !act_loop_q && !lp_bypass;  // RL17 RL18
    pll_en_d   = act_loop_q && !lp_bypass;   // RL17
    locked_d   = locked_q;
    lock_cnt_d = lock_cnt_q;
    if (!(fll_en_d || pll_en_d) || cfg_d != cfg_q) begin
      locked_d   = 1'b0;
      lock_cnt_d = '0;
    end else if (lock_cnt_q == LOCK_W'(LOCK_CYCS - 1)) begin
      locked_d = 1'b1;  // RL16 RL18
    end else begin
      lock_cnt_d = lock_cnt_q + LOCK_W'(1);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fll_en_q   <= 1'b1;
      pll_en_q   <= 1'b0;
      mult_q     <= 4'h0;
      locked_q   <= 1'b0;
      lock_cnt_q <= '0;
      cfg_q      <= {CTRL_ONE_RST[REF_DIV_HI:REF_DIV_LO], 4'h0, 1'b0, 1'b1};
    end else begin
      fll_en_q   <= fll_en_d;
      pll_en_q   <= pll_en_d;
      mult_q     <= mult_d;
      locked_q   <= locked_d;
      lock_cnt_q <= lock_cnt_d;
      cfg_q      <= cfg_d;
    end
  end

  assign fll_enable      = fll_en_q;
  assign pll_enable      = pll_en_q;
  assign loop_multiplier = mult_q;
  assign loop_locked     = locked_q;

  // ****************************************************************
  // output and bus clock enables
  // ****************************************************************
  logic [2:0] div_cnt_q, div_cnt_d;
  logic       gen_en_q, gen_en_d;
  logic       phase_q, phase_d;
  logic       bus_en_q, bus_en_d;
  logic [2:0] div_last;

  // divide by 1, 2, 4 or 8
  assign div_last = 3'((4'h1 << ctrl_two_q[BUS_DIV_HI:BUS_DIV_LO]) - 4'h1);  // RL1

  always_comb begin
    gen_en_d  = (div_cnt_q >= div_last);  // RL1
    div_cnt_d = gen_en_d ? 3'h0 : div_cnt_q + 3'h1;
    phase_d   = gen_en_d ? !phase_q : phase_q;
    bus_en_d  = gen_en_d && phase_q;  // RL19
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_q <= 3'h0;
      gen_en_q  <= 1'b0;
      phase_q   <= 1'b0;
      bus_en_q  <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      gen_en_q  <= gen_en_d;
      phase_q   <= phase_d;
      bus_en_q  <= bus_en_d;
    end
  end

  assign gen_clk_en = gen_en_q;
  assign bus_clk_en = bus_en_q;

  // ****************************************************************
  // read port
  // ****************************************************************
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] status;

  assign status = {1'b0, locked_q, act_loop_q, act_int_q, act_src_q, osc_rdy_q, 1'b0};

  always_comb begin
    rdata_d = 8'h00;
    if (rd_en) begin
      case (addr)
        ADDR_CTRL_ONE:   rdata_d = ctrl_one_q;
        ADDR_CTRL_TWO:   rdata_d = ctrl_two_q;
        ADDR_CTRL_THREE: rdata_d = ctrl_three_q;
        ADDR_STATUS:     rdata_d = status;  // RL5 RL9 RL10 RL15 RL16
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  chk_div_by_one: assert property ( // RL1
    ctrl_two_q[BUS_DIV_HI:BUS_DIV_LO] == 2'h0 && $stable(ctrl_two_q) |=> gen_clk_en)
    else $error("output enable missing with divide by one");

  chk_bus_half: assert property ( // RL19
    bus_clk_en |-> gen_clk_en ##1 !bus_clk_en)
    else $error("bus enable not half of output enable");

  chk_osc_start: assert property ( // RL5
    $rose(osc_rdy_q) |-> $past(osc_needed) && $past(osc_cnt_q) == OSC_W'(OSC_CYC - 1))
    else $error("oscillator ready before start-up count");

  chk_src_switch: assert property ( // RL23
    $changed(act_src_q) |-> $past(switch_done) && act_src_q == $past(tgt_src))
    else $error("active source changed without completed switch");

  chk_ref_status: assert property ( // RL9
    $changed(act_int_q) |-> act_int_q == $past(int_ref_sel))
    else $error("reference status disagrees with select");

  chk_lp_loops_off: assert property ( // RL17
    lp_bypass |=> !fll_enable && !pll_enable)
    else $error("loop running in low power bypass");

  chk_bypass_fll_on: assert property ( // RL18
    !low_pwr && !act_loop_q |=> fll_enable)
    else $error("fll stopped outside low power");

  chk_mult_ignored: assert property ( // RL14
    !act_loop_q |=> loop_multiplier == 4'h0)
    else $error("multiplier active with fll selected");

  chk_lock_enabled: assert property ( // RL16
    loop_locked |-> fll_enable || pll_enable)
    else $error("lock reported with both loops off");

  chk_read_status: assert property ( // RL10
    rd_en && addr == ADDR_STATUS |=> rdata[3:2] == $past(act_src_q)
      ##1 (rdata == 8'h00 || $past(rd_en)))
    else $error("status read data wrong or late");

  cov_pll_engaged: cover property (act_src_q == ACT_PLL && loop_locked);
  cov_lp_internal: cover property (clock_mode == low_power_internal_bypass);
  cov_osc_ready:   cover property ($rose(osc_rdy_q));
  cov_ext_bypass:  cover property (act_src_q == ACT_EXT && !act_int_q);

endmodule : clock_generator_mode_control

/* File: tb/clock_generator_mode_control_tb.sv */
// self-checking bench for the clock generator mode control
`timescale 1ns/10ps
module clock_generator_mode_control_tb
  import clkgen_pkg::*;
;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        clock;
  logic        reset_n;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rdata;
  logic        osc_range_high;
  logic        high_gain_osc;
  logic        ext_ref_select;
  logic        ext_ref_clock_enable;
  logic        fll_enable;
  logic        pll_enable;
  logic [2:0]  reference_divider;
  logic [3:0]  loop_multiplier;
  logic        loop_locked;
  logic [1:0]  clock_source_active;
  clock_mode_e clock_mode;
  logic        gen_clk_en;
  logic        bus_clk_en;
  int          fails;
  int          n_tests;
  int          cycles;
  logic [7:0]  rv;

  clock_generator_mode_control #(.OSC_CYC(4), .LOCK_CYCS(4), .SWITCH_CYCS(1)) dut (
    .clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .osc_range_high(osc_range_high),
    .high_gain_osc(high_gain_osc), .ext_ref_select(ext_ref_select),
    .ext_ref_clock_enable(ext_ref_clock_enable), .fll_enable(fll_enable),
    .pll_enable(pll_enable), .reference_divider(reference_divider),
    .loop_multiplier(loop_multiplier), .loop_locked(loop_locked),
    .clock_source_active(clock_source_active), .clock_mode(clock_mode),
    .gen_clk_en(gen_clk_en), .bus_clk_en(bus_clk_en));

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  // a hung poll ends the run here
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fails++;
      conclude();
    end
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_cyc

  // reads status until the masked bits match, bounded
  task automatic poll(input logic [7:0] mask, input logic [7:0] val, input string what);
    logic [7:0] d;
    int         i;
    d = ~val;
    for (i = 0; i < 60 && (d & mask) !== val; i++) begin
      rd(ADDR_STATUS, d);
    end
    check(what, val, d & mask);
  endtask : poll

  task automatic pulses(input logic [7:0] eg, input logic [7:0] eb);
    logic [7:0] g;
    logic [7:0] b;
    g = 8'h00;
    b = 8'h00;
    repeat (16) begin
      @(posedge clock);
      #1;
      g = g + {7'h00, gen_clk_en};
      b = b + {7'h00, bus_clk_en};
    end
    check("output clock pulses", eg, g);
    check("bus clock pulses", eb, b);
  endtask : pulses

  task automatic mode_is(input clock_mode_e m);
    check("clock mode", {5'h00, m}, {5'h00, clock_mode});
  endtask : mode_is

  task automatic loops_are(input logic f, input logic p);
    check("loop enables", {6'h00, f, p}, {6'h00, fll_enable, pll_enable});
  endtask : loops_are

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    mode_is(fll_internal_mode);
    loops_are(1'b1, 1'b0);
    pulses(8'h08, 8'h04);
    rd(ADDR_CTRL_ONE, rv);
    check("control one", CTRL_ONE_RST, rv);
    rd(ADDR_CTRL_TWO, rv);
    check("control two", CTRL_TWO_RST, rv);
    rd(ADDR_CTRL_THREE, rv);
    check("control three", CTRL_THREE_RST, rv);
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, rv);
    check("status", 8'h10, rv & 8'hbf);
    rd(3'h6, rv);
    check("unmapped read", 8'h00, rv);
    $display("test reset done");
  endtask : t_reset

  task automatic t_to_fbe();
    wr(ADDR_CTRL_TWO, 8'h36);
    check("osc controls", 8'h0f, {4'h0, osc_range_high, high_gain_osc,
          ext_ref_select, ext_ref_clock_enable});
    pulses(8'h10, 8'h08);
    poll(8'h02, 8'h02, "osc ready");
    wr(ADDR_CTRL_ONE, 8'hb8);
    check("ref divider", 8'h07, {5'h00, reference_divider});
    poll(8'h1c, 8'h08, "external active");
    mode_is(fll_bypass_external_mode);
    poll(8'h40, 8'h40, "fll lock in bypass");
    $display("test external bypass done");
  endtask : t_to_fbe

  task automatic t_to_pee();
    wr(ADDR_CTRL_TWO, 8'h3e);
    wait_cyc(2);
    mode_is(low_power_external_bypass);
    loops_are(1'b0, 1'b0);
    wr(ADDR_CTRL_ONE, 8'h90);
    check("ref divider", 8'h02, {5'h00, reference_divider});
    wr(ADDR_CTRL_THREE, 8'h44);
    poll(8'h20, 8'h20, "pll selected");
    loops_are(1'b0, 1'b0);
    wr(ADDR_CTRL_TWO, 8'h36);
    poll(8'h40, 8'h40, "pll lock");
    check("lock pin", 8'h01, {7'h00, loop_locked});
    mode_is(pll_bypass_external_mode);
    check("pll running", 8'h01, {7'h00, pll_enable});
    wr(ADDR_CTRL_ONE, 8'h10);
    poll(8'h0c, 8'h0c, "pll feeds output");
    check("active pins", {6'h00, ACT_PLL}, {6'h00, clock_source_active});
    mode_is(pll_external_mode);
    check("multiplier", 8'h04, {4'h0, loop_multiplier});
    $display("test pll engaged done");
  endtask : t_to_pee

  task automatic t_to_low_power_internal_bypass();
    wr(ADDR_CTRL_ONE, 8'h90);
    poll(8'h0c, 8'h08, "back to external");
    wr(ADDR_CTRL_THREE, 8'h04);
    poll(8'h20, 8'h00, "fll selected");
    wait_cyc(2);
    check("multiplier", 8'h00, {4'h0, loop_multiplier});
    check("fll running", 8'h01, {7'h00, fll_enable});
    poll(8'h40, 8'h40, "fll relock");
    wr(ADDR_CTRL_ONE, 8'h44);
    poll(8'h1c, 8'h14, "internal active");
    mode_is(fll_bypass_internal_mode);
    wr(ADDR_CTRL_TWO, 8'h08);
    wait_cyc(2);
    mode_is(low_power_internal_bypass);
    loops_are(1'b0, 1'b0);
    wr(ADDR_CTRL_TWO, 8'h00);
    wait_cyc(2);
    check("fll running", 8'h01, {7'h00, fll_enable});
    $display("test low power internal done");
  endtask : t_to_low_power_internal_bypass

  task automatic t_to_fee();
    wr(ADDR_CTRL_TWO, 8'h36);
    poll(8'h02, 8'h02, "osc restart");
    wr(ADDR_CTRL_ONE, 8'h38);
    poll(8'h10, 8'h00, "external reference");
    poll(8'h0c, 8'h00, "fll feeds output");
    mode_is(fll_external_mode);
    check("active pins", {6'h00, ACT_FLL}, {6'h00, clock_source_active});
    poll(8'h40, 8'h40, "fll lock external");
    check("lock pin", 8'h01, {7'h00, loop_locked});
    $display("test fll external done");
  endtask : t_to_fee

  task automatic t_mid_reset();
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    t_reset();
    $display("test mid-run reset done");
  endtask : t_mid_reset

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset_n = 1'b0;
    addr    = 3'h0;
    wdata   = 8'h00;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    fails   = 0;
    n_tests = 0;
    cycles  = 0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    t_reset();
    t_to_fbe();
    t_to_pee();
    t_to_low_power_internal_bypass();
    t_to_fee();
    t_mid_reset();
    conclude();
  end

endmodule : clock_generator_mode_control_tb
